// file: rtl/big_ram_defines.vh
// constants for the large embedded ram block
`ifndef BIG_RAM_DEFINES_VH
`define BIG_RAM_DEFINES_VH
`define TOTAL_BITS      589824
`define UNIT_WIDTH      9
`define UNIT_DEPTH      65536
`define UNIT_ADDR_BITS  16
`define MAX_WIDTH       144
`define MAX_UNITS       16
`define MODE_TDP        2'h0
`define MODE_SDP        2'h1
`define MODE_SP         2'h2
`define MODE_FIFO       2'h3
`define W9              3'h0
`define W18             3'h1
`define W36             3'h2
`define W72             3'h3
`define W144            3'h4
`endif

// file: rtl/ram_port_pipe.v
// read output stage with optional output register
`timescale 1ns/1ps
module ram_port_pipe #(
  parameter WIDTH = 144
) (
  input  wire             clock,
  input  wire             reset,
  input  wire             useOutReg,
  input  wire [WIDTH-1:0] rawData,
  input  wire             rawValid,
  output reg  [WIDTH-1:0] dataOut_ff,
  output reg              validOut_ff
);
  reg [WIDTH-1:0] stage_ff;
  reg             stageValid_ff;

  // bypass drops one stage; top output still leaves a flop
  always @(posedge clock) begin
    if (reset) begin
      stage_ff      <= {WIDTH{1'b0}};
      stageValid_ff <= 1'b0;
      dataOut_ff    <= {WIDTH{1'b0}};
      validOut_ff   <= 1'b0;
    end else begin
      stage_ff      <= rawData;
      stageValid_ff <= rawValid;
      dataOut_ff    <= useOutReg ? stage_ff : rawData; // (R5)
      validOut_ff   <= useOutReg ? stageValid_ff : rawValid; // (R5)
    end
  end
endmodule

// file: rtl/large_embedded_ram_block.v
// large embedded ram block: dual-port, single-port and fifo modes
//
// Functional notes
// (R1) storage is 589824 bits including parity, shared by all width choices.
// (R2) the block runs as true dual-port, simple dual-port, single-port or fifo.
// (R3) contents are never preloaded and are undefined until written.
// (R4) every address, data and control input is registered before use.
// (R5) each read path has an output register that can be bypassed to save one stage.
// (R6) each port is 64Kx9, 32Kx18, 16Kx36, 8Kx72 or 4Kx144, parity bits optional.
// (R7) the 144-bit width is refused in true dual-port mode.
// (R8) read and write widths may differ, each addressing the same storage.
// (R9) in simple dual-port, widths 9 to 72 mix freely and 144 pairs only with 144.
// (R10) fifo mode keeps its own pointers, flags full and empty, drops bad accesses.
// (R11) user logic writes each location before reading it.
`timescale 1ns/1ps
`include "big_ram_defines.vh"
module large_embedded_ram_block #(
  parameter AW = `UNIT_ADDR_BITS,
  parameter DW = `MAX_WIDTH
) (
  input  wire          clock,
  input  wire          reset,
  input  wire [1:0]    mode,
  input  wire [2:0]    widthA,
  input  wire [2:0]    widthB,
  input  wire          outRegA,
  input  wire          outRegB,
  input  wire          enA,
  input  wire          weA,
  input  wire [AW-1:0] addrA,
  input  wire [DW-1:0] wdataA,
  input  wire          enB,
  input  wire          weB,
  input  wire [AW-1:0] addrB,
  input  wire [DW-1:0] wdataB,
  output wire [DW-1:0] rdataA,
  output wire          rvalidA,
  output wire [DW-1:0] rdataB,
  output wire          rvalidB,
  output reg           configError_ff,
  output reg           fifoFull_ff,
  output reg           fifoEmpty_ff
);
  localparam UNITS = `MAX_UNITS;
  localparam ROWS  = `TOTAL_BITS / DW;
  localparam RAW   = 12;

  // row of 144 bits, 4096 rows; no initial block, contents undefined
  reg [DW-1:0] mem [0:ROWS-1]; // (R1) (R3)

  reg [1:0]    mode_ff;
  reg [2:0]    widthA_ff;
  reg [2:0]    widthB_ff;
  reg          outRegA_ff;
  reg          outRegB_ff;
  reg          enA_ff;
  reg          weA_ff;
  reg [AW-1:0] addrA_ff;
  reg [DW-1:0] wdataA_ff;
  reg          enB_ff;
  reg          weB_ff;
  reg [AW-1:0] addrB_ff;
  reg [DW-1:0] wdataB_ff;
  reg [AW:0]   wrPtr_ff;
  reg [AW:0]   rdPtr_ff;
  reg [DW-1:0] rowA_ff;
  reg [DW-1:0] rowB_ff;
  reg [3:0]    laneA_ff;
  reg [3:0]    laneB_ff;
  reg [2:0]    rwA_ff;
  reg [2:0]    rwB_ff;
  reg          rvA_ff;
  reg          rvB_ff;

  // all inputs registered first
  always @(posedge clock) begin
    if (reset) begin
      mode_ff    <= `MODE_SP;
      widthA_ff  <= `W9;
      widthB_ff  <= `W9;
      outRegA_ff <= 1'b0;
      outRegB_ff <= 1'b0;
      enA_ff     <= 1'b0;
      weA_ff     <= 1'b0;
      addrA_ff   <= {AW{1'b0}};
      wdataA_ff  <= {DW{1'b0}};
      enB_ff     <= 1'b0;
      weB_ff     <= 1'b0;
      addrB_ff   <= {AW{1'b0}};
      wdataB_ff  <= {DW{1'b0}};
    end else begin
      mode_ff    <= mode; // (R4)
      widthA_ff  <= widthA;
      widthB_ff  <= widthB;
      outRegA_ff <= outRegA;
      outRegB_ff <= outRegB;
      enA_ff     <= enA;
      weA_ff     <= weA;
      addrA_ff   <= addrA;
      wdataA_ff  <= wdataA;
      enB_ff     <= enB;
      weB_ff     <= weB;
      addrB_ff   <= addrB;
      wdataB_ff  <= wdataB;
    end
  end

  // legal width combinations per mode
  reg cfgBad;
  always @* begin
    cfgBad = (widthA_ff > `W144) || (widthB_ff > `W144); // (R6)
    case (mode_ff)
      `MODE_TDP:  cfgBad = cfgBad || widthA_ff == `W144 || widthB_ff == `W144; // (R7)
      `MODE_SDP:  cfgBad = cfgBad || ((widthA_ff == `W144) != (widthB_ff == `W144)); // (R9)
      `MODE_SP:   cfgBad = cfgBad;
      `MODE_FIFO: cfgBad = cfgBad || ((widthA_ff == `W144) != (widthB_ff == `W144));
      default:    cfgBad = 1'b1;
    endcase
  end

  // fifo pointers count 9-bit units, stepping by the write width on A, read width on B
  wire fifoMode = (mode_ff == `MODE_FIFO);
  reg  [AW:0] stepA;
  reg  [AW:0] stepB;
  always @* begin
    stepA = {{AW{1'b0}}, 1'b1} << widthA_ff;
    stepB = {{AW{1'b0}}, 1'b1} << widthB_ff;
  end
  wire [AW:0] used    = wrPtr_ff - rdPtr_ff;
  wire [AW:0] freeCnt = {1'b1, {AW{1'b0}}} - used;
  wire        canWr   = freeCnt >= stepA;
  wire        canRd   = used >= stepB;

  // port roles: A writes, B reads in sdp and fifo; sp uses A only
  wire aWrite = enA_ff && weA_ff && !cfgBad && (!fifoMode || canWr); // (R10)
  wire aRead  = enA_ff && !weA_ff && !cfgBad && (mode_ff == `MODE_TDP || mode_ff == `MODE_SP);
  wire bWrite = enB_ff && weB_ff && !cfgBad && mode_ff == `MODE_TDP;
  wire bRead  = enB_ff && !weB_ff && !cfgBad && (mode_ff == `MODE_TDP ||
                mode_ff == `MODE_SDP || (fifoMode && canRd)); // (R10)
  wire [AW-1:0] effA = fifoMode ? wrPtr_ff[AW-1:0] : addrA_ff;
  wire [AW-1:0] effB = fifoMode ? rdPtr_ff[AW-1:0] : addrB_ff;

  // word address shifted by width to a unit address, then split into row and 9-bit lane
  function [RAW+3:0] locate;
    input [AW-1:0] ua;
    input [2:0]    w;
    reg   [AW-1:0] al;
    begin
      al     = ua << w;
      locate = {al[AW-1:4], al[3:0]};
    end
  endfunction
  // fifo pointers already count 9-bit units; scaling them again would wrap rows
  wire [RAW+3:0] locA = fifoMode ? effA : locate(effA, widthA_ff); // (R8)
  wire [RAW+3:0] locB = fifoMode ? effB : locate(effB, widthB_ff); // (R8)

  // merge write data into a row at the unit lanes it covers
  function [DW-1:0] merge;
    input [DW-1:0] row;
    input [DW-1:0] wd;
    input [3:0]    lane;
    input [2:0]    w;
    integer        u;
    reg   [DW-1:0] r;
    begin
      r = row;
      for (u = 0; u < UNITS; u = u + 1) begin
        if (u >= lane && u < lane + (5'h01 << w))
          r[u*`UNIT_WIDTH +: `UNIT_WIDTH] = wd[(u-lane)*`UNIT_WIDTH +: `UNIT_WIDTH];
      end
      merge = r;
    end
  endfunction

  function [DW-1:0] extract;
    input [DW-1:0] row;
    input [3:0]    lane;
    input [2:0]    w;
    reg   [DW-1:0] sh;
    begin
      sh = row >> (lane * `UNIT_WIDTH);
      case (w)
        `W9:     extract = {{(DW-9){1'b0}}, sh[8:0]};
        `W18:    extract = {{(DW-18){1'b0}}, sh[17:0]};
        `W36:    extract = {{(DW-36){1'b0}}, sh[35:0]};
        `W72:    extract = {{(DW-72){1'b0}}, sh[71:0]};
        default: extract = sh;
      endcase
    end
  endfunction

  // read-first on collisions: a read gets the old row, and B's write wins a same-row clash with A
  always @(posedge clock) begin
    if (aWrite)
      mem[locA[RAW+3:4]] <= merge(mem[locA[RAW+3:4]], wdataA_ff, locA[3:0], widthA_ff); // (R2)
    if (bWrite)
      mem[locB[RAW+3:4]] <= merge(mem[locB[RAW+3:4]], wdataB_ff, locB[3:0], widthB_ff); // (R2)
    rowA_ff  <= mem[locA[RAW+3:4]];
    rowB_ff  <= mem[locB[RAW+3:4]];
    laneA_ff <= locA[3:0];
    laneB_ff <= locB[3:0];
    rwA_ff   <= widthA_ff;
    rwB_ff   <= widthB_ff;
  end

  always @(posedge clock) begin
    if (reset) begin
      rvA_ff         <= 1'b0;
      rvB_ff         <= 1'b0;
      wrPtr_ff       <= {(AW+1){1'b0}};
      rdPtr_ff       <= {(AW+1){1'b0}};
      configError_ff <= 1'b0;
      fifoFull_ff    <= 1'b0;
      fifoEmpty_ff   <= 1'b1;
    end else begin
      rvA_ff         <= aRead;
      rvB_ff         <= bRead;
      configError_ff <= cfgBad; // (R7) (R9)
      if (!fifoMode) begin
        wrPtr_ff <= {(AW+1){1'b0}};
        rdPtr_ff <= {(AW+1){1'b0}};
      end else begin
        if (aWrite)
          wrPtr_ff <= wrPtr_ff + stepA; // (R10)
        if (bRead)
          rdPtr_ff <= rdPtr_ff + stepB; // (R10)
      end
      // flags lag pointers by one cycle; accesses are gated on live counts
      fifoFull_ff  <= fifoMode && !canWr; // (R10)
      fifoEmpty_ff <= !fifoMode || !canRd; // (R10)
    end
  end

  ram_port_pipe #(.WIDTH(DW)) pipeA (
    .clock      (clock),
    .reset      (reset),
    .useOutReg  (outRegA_ff),
    .rawData    (extract(rowA_ff, laneA_ff, rwA_ff)),
    .rawValid   (rvA_ff),
    .dataOut_ff (rdataA),
    .validOut_ff(rvalidA)
  );

  ram_port_pipe #(.WIDTH(DW)) pipeB (
    .clock      (clock),
    .reset      (reset),
    .useOutReg  (outRegB_ff),
    .rawData    (extract(rowB_ff, laneB_ff, rwB_ff)),
    .rawValid   (rvB_ff),
    .dataOut_ff (rdataB),
    .validOut_ff(rvalidB)
  );
endmodule

// file: tb/large_embedded_ram_block_sva.sv
// port assertions for the large ram block
`timescale 1ns/1ps
module large_embedded_ram_block_sva (
  input wire       clock,
  input wire       reset,
  input wire [1:0] mode,
  input wire [2:0] widthA,
  input wire [2:0] widthB,
  input wire       outRegB,
  input wire       enB,
  input wire       weB,
  input wire       rvalidB,
  input wire       configError_ff,
  input wire       fifoFull_ff,
  input wire       fifoEmpty_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // only legal true dual-port reads are checked for their fixed answer time
  wire rdB = enB && !weB && mode == 2'h0 && widthB < 3'h4 && !configError_ff;
  chk_reset_clear: assert property (disable iff (1'b0) reset |=> !rvalidB && fifoEmpty_ff
    && !fifoFull_ff && !configError_ff) else $error("outputs not cleared by reset");
  chk_bypass_read: assert property (rdB && !outRegB |-> ##3 rvalidB)
    else $error("bypassed read late or missing");
  chk_outreg_read: assert property (rdB && outRegB |-> ##4 rvalidB)
    else $error("registered read late or missing");
  chk_valid_cause: assert property (rvalidB |-> $past(enB && !weB, 3) || $past(enB && !weB, 4))
    else $error("read data without a request");
  chk_tdp_wide: assert property ((mode == 2'h0 && widthA == 3'h4) [*4] |-> configError_ff)
    else $error("wide true dual-port accepted");
  chk_sdp_mix: assert property ((mode == 2'h1 && widthA == 3'h4 && widthB != 3'h4) [*4]
    |-> configError_ff) else $error("wide width mixed");
  chk_sdp_legal: assert property ((mode == 2'h1 && widthA < 3'h4 && widthB < 3'h4) [*4]
    |-> !configError_ff) else $error("legal mix refused");
  chk_empty_idle: assert property ((mode != 2'h3) [*5] |-> fifoEmpty_ff && !fifoFull_ff)
    else $error("fifo flags outside fifo mode");
  chk_sp_quiet: assert property ((mode == 2'h2) [*6] |-> !rvalidB)
    else $error("port b active in single-port mode");
endmodule
bind large_embedded_ram_block large_embedded_ram_block_sva i_chk (.clock(clock), .reset(reset),
  .mode(mode), .widthA(widthA), .widthB(widthB), .outRegB(outRegB), .enB(enB), .weB(weB),
  .rvalidB(rvalidB), .configError_ff(configError_ff), .fifoFull_ff(fifoFull_ff),
  .fifoEmpty_ff(fifoEmpty_ff));

// file: tb/user_shadow.sv
// user-side record of which units were written
`timescale 1ns/1ps
module user_shadow (
  input  wire        clock,
  input  wire        enA,
  input  wire        weA,
  input  wire [15:0] addrA,
  input  wire [15:0] addrB,
  output wire        knownB
);
  // unwritten units stay unknown, so knownB never passes by accident
  reg unitWritten_ff [0:65535];
  always @(posedge clock) begin
    if (enA && weA)
      unitWritten_ff[addrA] <= 1'b1;
  end
  assign knownB = unitWritten_ff[addrB];
endmodule

// file: tb/large_embedded_ram_block_tb_top.sv
// testbench for the large ram block
`timescale 1ns/1ps
module large_embedded_ram_block_tb_top;
  reg          clock = 1'b0;
  reg          reset = 1'b1;
  reg  [1:0]   mode = 2'h0;
  reg  [2:0]   widthA = 3'h0;
  reg  [2:0]   widthB = 3'h0;
  reg          outRegB = 1'b0;
  reg          outRegA = 1'b0;
  reg          weB = 1'b0;
  reg  [143:0] wdataB = 144'h0;
  wire [143:0] rdataA;
  wire         rvalidA;
  reg          enA = 1'b0;
  reg          weA = 1'b0;
  reg          enB = 1'b0;
  reg  [15:0]  addrA = 16'h0000;
  reg  [15:0]  addrB = 16'h0000;
  reg  [143:0] wdataA = 144'h0;
  wire [143:0] rdataB;
  wire         rvalidB;
  wire         configError_ff;
  wire         fifoFull_ff;
  wire         fifoEmpty_ff;
  wire         knownB;
  integer      bad_count = 0;
  integer      n_compared = 0;
  always #4 clock = ~clock;
  large_embedded_ram_block i_dut (.clock(clock), .reset(reset), .mode(mode), .widthA(widthA),
    .widthB(widthB), .outRegA(outRegA), .outRegB(outRegB), .enA(enA), .weA(weA), .addrA(addrA),
    .wdataA(wdataA), .enB(enB), .weB(weB), .addrB(addrB), .wdataB(wdataB), .rdataA(rdataA),
    .rvalidA(rvalidA), .rdataB(rdataB), .rvalidB(rvalidB), .configError_ff(configError_ff),
    .fifoFull_ff(fifoFull_ff), .fifoEmpty_ff(fifoEmpty_ff));
  user_shadow i_user (.clock(clock), .enA(enA), .weA(weA), .addrA(addrA), .addrB(addrB),
    .knownB(knownB));
  task check(input [143:0] seen, input [143:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task cfg(input [1:0] m, input [2:0] wa, input [2:0] wb, input o);
    begin
      @(posedge clock);
      #1;
      mode = m;
      widthA = wa;
      widthB = wb;
      outRegB = o;
      repeat (5) @(posedge clock);
      #1;
    end
  endtask
  task wr(input [15:0] a, input [143:0] d);
    begin
      @(posedge clock);
      #1;
      enA = 1'b1;
      weA = 1'b1;
      addrA = a;
      wdataA = d;
      @(posedge clock);
      #1;
      enA = 1'b0;
    end
  endtask
  // one read on port b; stops the run if an expected answer never comes
  task rd(input [15:0] a, input v, input [143:0] want);
    integer i;
    reg     got;
    begin
      got = 1'b0;
      @(posedge clock);
      #1;
      enB = 1'b1;
      addrB = a;
      @(posedge clock);
      #1;
      enB = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        if (rvalidB === 1'b1 && !got) begin
          got = 1'b1;
          check(rdataB, want);
        end
        @(posedge clock);
        #1;
      end
      check(got, v);
      if (v && !got)
        test_done;
    end
  endtask
  // b writes in true dual-port, a reads it back through its output register
  task tdp_cross(input [15:0] a, input [143:0] d, input [143:0] want);
    integer i;
    reg     got;
    begin
      got = 1'b0;
      @(posedge clock);
      #1;
      enB = 1'b1;
      weB = 1'b1;
      addrB = a;
      wdataB = d;
      @(posedge clock);
      #1;
      enB = 1'b0;
      weB = 1'b0;
      enA = 1'b1;
      weA = 1'b0;
      addrA = a;
      @(posedge clock);
      #1;
      enA = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        if (rvalidA === 1'b1 && !got) begin
          got = 1'b1;
          check(rdataA, want);
        end
        @(posedge clock);
        #1;
      end
      check(got, 1'b1);
      if (!got)
        test_done;
    end
  endtask
  // x144 words until full; the last write must be dropped
  task fifo_fill;
    integer i;
    begin
      @(posedge clock);
      #1;
      enA = 1'b1;
      weA = 1'b1;
      for (i = 0; i < 4097; i = i + 1) begin
        wdataA = {8'hC3, 120'h0, i[15:0]};
        @(posedge clock);
        #1;
      end
      enA = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check(fifoFull_ff, 1'b1);
      check(fifoEmpty_ff, 1'b0);
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset = 1'b0;
    check(fifoEmpty_ff, 1'b1);
    cfg(2'h0, 3'h0, 3'h1, 1'b0);
    wr(16'h0000, 144'h1A5);
    wr(16'h0001, 144'h0F0);
    rd(16'h0000, 1'b1, 144'h1E1A5);
    check(knownB, 1'b1);
    cfg(2'h0, 3'h0, 3'h1, 1'b1);
    rd(16'h0000, 1'b1, 144'h1E1A5);
    outRegA = 1'b1;
    cfg(2'h0, 3'h2, 3'h2, 1'b0);
    tdp_cross(16'h0005, 144'hABCF12345678, 144'h0F12345678);
    cfg(2'h1, 3'h2, 3'h0, 1'b0);
    check(configError_ff, 1'b0);
    wr(16'h0010, {108'h0, 9'h155, 9'h0AA, 9'h1FF, 9'h001});
    rd(16'h0040, 1'b1, 144'h001);
    rd(16'h0043, 1'b1, 144'h155);
    cfg(2'h0, 3'h4, 3'h4, 1'b0);
    check(configError_ff, 1'b1);
    cfg(2'h1, 3'h4, 3'h1, 1'b0);
    check(configError_ff, 1'b1);
    cfg(2'h1, 3'h4, 3'h4, 1'b0);
    check(configError_ff, 1'b0);
    wr(16'h0FFF, {16{9'h1C7}});
    rd(16'h0FFF, 1'b1, {16{9'h1C7}});
    cfg(2'h2, 3'h0, 3'h0, 1'b0);
    rd(16'h0000, 1'b0, 144'h0);
    cfg(2'h3, 3'h0, 3'h0, 1'b0);
    rd(16'h0000, 1'b0, 144'h0);
    wr(16'h0000, 144'h0C3);
    repeat (5) @(posedge clock);
    #1;
    check(fifoEmpty_ff, 1'b0);
    rd(16'h0000, 1'b1, 144'h0C3);
    repeat (5) @(posedge clock);
    #1;
    check(fifoEmpty_ff, 1'b1);
    cfg(2'h2, 3'h4, 3'h4, 1'b0);
    cfg(2'h3, 3'h4, 3'h4, 1'b0);
    fifo_fill;
    rd(16'h0000, 1'b1, {8'hC3, 120'h0, 16'h0000});
    check(fifoFull_ff, 1'b0);
    rd(16'h0000, 1'b1, {8'hC3, 120'h0, 16'h0001});
    test_done;
  end
endmodule
